// file: logic/ioc_pkg.sv
// Package for the internal oscillator control block: SFR addresses, field positions,
// reset images and divider encodings.
// Assumes an 8-bit SFR bus with an 8-bit address and a register page number.
package ioc_pkg;
  localparam logic [7:0] HF_CTRL_ADDR     = 8'hB2;
  localparam logic [7:0] MULT_ADDR        = 8'hB9;
  localparam logic [7:0] MULT_PAGE        = 8'h00;
  localparam int         HF_ON_BIT        = 7;
  localparam int         HF_RDY_BIT       = 6;
  localparam int         HF_SUSP_BIT      = 5;
  localparam int         DIV_LSB          = 0;
  localparam logic [7:0] HF_CTRL_RESET    = 8'hC0;
  localparam logic [7:0] MULT_IMAGE       = 8'hE0;
  localparam logic [1:0] HF_DIV_RESET     = 2'h0;
  localparam logic [1:0] LF_DIV_RESET     = 2'h0;
  localparam logic [1:0] LF_TRIM_DUMMY    = 2'h0;
  localparam logic [3:0] LF_TRIM_RESET    = 4'h0;
  localparam logic [1:0] FIXED_PREDIV     = 2'h3;
  localparam logic [2:0] CLKSEL_HF_SCALED = 3'h0;
  localparam int         HF_SETTLE_CYC    = 16;
  typedef enum logic [1:0] {IOC_OFF, IOC_SETTLE, IOC_RUN, IOC_SUSP} ioc_state_t;
endpackage : ioc_pkg

// file: logic/ioc_top.sv
// Internal oscillator control: control/status register, multiplier compatibility
// register, system clock enable divider and low-frequency capture strobes.
// Assumes core_clk stands for the oscillator; SFR write strobe is one cycle wide.
//
// Function
// [RL1] Control bit 7 enables the high-frequency oscillator; resets to one.
// [RL2] Read-only bit 6 reports oscillator at programmed frequency; resets to one.
// [RL3] Writing one to bit 5 suspends the oscillator; wake restarts; resets zero.
// [RL4] Bits 4 to 2 of both registers read zero; writes ignored.
// [RL5] Oscillator passes fixed divide by four, then divider field bits 1:0.
// [RL6] Divider field 00..11 gives divide by 8,4,2,1; resets to 00.
// [RL7] Multiplier register appears as a present, working, ready multiplier.
// [RL8] Multiplier enable, init and ready bits always read one.
// [RL9] Multiplier input select bits 1:0 always read 00; writes ignored.
// [RL10] Control register decodes at 0xB2 on every register page.
// [RL11] Multiplier register decodes at 0xB9 only on page zero.
// [RL12] Low-frequency path divides its output by 1, 2, 4 or 8.
// [RL13] Four-bit trim field adjusts the low-frequency oscillator frequency.
// [RL14] Capture mode: timer 2 on falling, timer 3 on rising edge of low clock.
// [RL15] Each capture copies the timer count into the reload register pair.
// [RL16] Low divider field 00..11 gives divide by 8,4,2,1; resets to 00.
// [RL17] Suspend wakes on non-idle bus event or supply detect edge either way.
// [RL18] Clock select 000 takes the divided high-frequency clock as system clock.
// [RL19] Suspend bit reads one while suspended; hardware clears it on wake.
// [RL20] Ready flag low while disabled or suspended; returns once settled.
`timescale 1ns/1ps
module ioc_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // SFR bus
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_page,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // Clock settings from neighbouring registers
  input  wire logic [2:0]  sys_clock_select,
  input  wire logic [1:0]  lf_divider_select,
  input  wire logic [3:0]  lf_trim,
  // Wake sources, asynchronous
  input  wire logic        usb_wake_event,
  input  wire logic        bus_supply_detect,
  // Low-frequency oscillator raw output, asynchronous
  input  wire logic        lf_osc_raw,
  // Timer capture
  input  wire logic        t2_lf_capture_mode,
  input  wire logic        t3_lf_capture_mode,
  input  wire logic [15:0] t2_count,
  input  wire logic [15:0] t3_count,
  // Oscillator, clock and timer capture outputs
  output logic             hf_osc_on,
  output logic             hf_osc_suspend,
  output logic             hf_freq_ready,
  output logic             system_clock_en,
  output logic             lf_clock_en,
  output logic      [3:0]  lf_trim_out,
  output logic             t2_capture,
  output logic             t3_capture,
  output logic      [15:0] t2_reload,
  output logic      [15:0] t3_reload
);

  // Register state, all in one struct
  typedef struct packed {
    // Oscillator control and status
    ioc_pkg::ioc_state_t st;
    logic [4:0]          settle;
    logic                on;
    logic                susp;
    logic                rdy;
    logic [1:0]          hf_div;
    // System clock divider
    logic [4:0]          hf_cnt;
    logic                sys_en;
    // Low-frequency divider and trim
    logic [1:0]          lf_sel_last;
    logic [2:0]          lf_cnt;
    logic                lf_en;
    logic [3:0]          trim;
    // Synchronisers: two settled flops plus one history flop each
    logic [2:0]          usb_s;
    logic [2:0]          bus_s;
    logic [2:0]          lf_s;
    // Timer capture
    logic                cap2;
    logic                cap3;
    logic [15:0]         rl2;
    logic [15:0]         rl3;
    // Register read path
    logic [7:0]          rdata;
    logic                hit;
  } ioc_reg_t;

  // Reset image: oscillator enabled and already at frequency
  localparam ioc_reg_t RST_IMG = '{
    // Oscillator control and status
    st:          ioc_pkg::IOC_RUN,
    settle:      5'h00,
    on:          ioc_pkg::HF_CTRL_RESET[ioc_pkg::HF_ON_BIT],
    susp:        ioc_pkg::HF_CTRL_RESET[ioc_pkg::HF_SUSP_BIT],
    rdy:         ioc_pkg::HF_CTRL_RESET[ioc_pkg::HF_RDY_BIT],
    hf_div:      ioc_pkg::HF_DIV_RESET,
    // System clock divider
    hf_cnt:      5'h00,
    sys_en:      1'b0,
    // Low-frequency divider and trim
    lf_sel_last: ioc_pkg::LF_DIV_RESET,
    lf_cnt:      3'h0,
    lf_en:       1'b0,
    trim:        ioc_pkg::LF_TRIM_RESET,
    // Synchronisers
    usb_s:       3'h0,
    bus_s:       3'h0,
    lf_s:        3'h0,
    // Timer capture
    cap2:        1'b0,
    cap3:        1'b0,
    rl2:         16'h0000,
    rl3:         16'h0000,
    // Register read path
    rdata:       8'h00,
    hit:         1'b0
  };

  // Current and next state
  ioc_reg_t r_q;
  ioc_reg_t r_d;

  // Divider field to terminal count: 00..11 give 8, 4, 2, 1
  function automatic logic [3:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    div_mask = 4'h7;
      2'h1:    div_mask = 4'h3;
      2'h2:    div_mask = 4'h1;
      default: div_mask = 4'h0;
    endcase
  endfunction : div_mask

  // One divider step: {wrapped, next count}; wraps when the count reaches the limit
  function automatic logic [5:0] div_step(input logic [4:0] cnt, input logic [4:0] lim);
    if (cnt >= lim) begin
      div_step = {1'b1, 5'h00};
    end else begin
      div_step = {1'b0, cnt + 5'h01};
    end
  endfunction : div_step

  // Address match; page zero only unless the register sits on every page
  function automatic logic sfr_match(input logic [7:0] addr, input logic [7:0] page,
                                     input logic [7:0] want, input logic all_pages);
    sfr_match = (addr == want) && (all_pages || (page == ioc_pkg::MULT_PAGE));
  endfunction : sfr_match

  // Edges of a synchronised pin: bit 1 is the newer settled sample, bit 2 the older
  function automatic logic is_rise(input logic [2:0] s);
    is_rise = s[1] && !s[2];
  endfunction : is_rise

  function automatic logic is_fall(input logic [2:0] s);
    is_fall = s[2] && !s[1];
  endfunction : is_fall

  // Decode and read image
  logic       ctrl_sel;
  logic       mult_sel;
  logic [7:0] ctrl_img;
  // Edges and divider terms
  logic       wake;
  logic       lf_rise;
  logic       lf_fall;
  logic [3:0] hf_mask;
  logic [3:0] lf_mask;
  logic [4:0] hf_limit;
  logic [5:0] hf_step;
  logic [5:0] lf_step;

  // Address decode and control read image
  always_comb begin
    ctrl_sel = sfr_match(sfr_addr, sfr_page, ioc_pkg::HF_CTRL_ADDR, 1'b1); // RL10
    mult_sel = sfr_match(sfr_addr, sfr_page, ioc_pkg::MULT_ADDR, 1'b0); // RL11
    ctrl_img = 8'h00; // RL4
    ctrl_img[ioc_pkg::HF_ON_BIT] = r_q.on; // RL1
    ctrl_img[ioc_pkg::HF_RDY_BIT] = r_q.rdy; // RL2
    ctrl_img[ioc_pkg::HF_SUSP_BIT] = r_q.susp; // RL19
    ctrl_img[ioc_pkg::DIV_LSB +: 2] = r_q.hf_div; // RL6
  end

  // Wake sources and low-frequency edges, read from settled flops only
  always_comb begin
    wake    = is_rise(r_q.usb_s) || (r_q.bus_s[2] != r_q.bus_s[1]); // RL17
    lf_rise = is_rise(r_q.lf_s);
    lf_fall = is_fall(r_q.lf_s);
  end

  // Divider limits: fixed divide by four below the programmable divider
  always_comb begin
    hf_mask  = div_mask(r_q.hf_div);
    hf_limit = {hf_mask[2:0], ioc_pkg::FIXED_PREDIV}; // RL5 RL6
    hf_step  = div_step(r_q.hf_cnt, hf_limit);
    // Low-frequency limit is the field's mask, counted in rising edges
    lf_mask  = div_mask(lf_divider_select);
    lf_step  = div_step({2'b00, r_q.lf_cnt}, {2'b00, lf_mask[2:0]});
  end

  always_comb begin
    r_d = r_q;

    // Two-flop synchronisers plus one history flop for edge detection
    r_d.usb_s = {r_q.usb_s[1:0], usb_wake_event};
    r_d.bus_s = {r_q.bus_s[1:0], bus_supply_detect};
    r_d.lf_s  = {r_q.lf_s[1:0], lf_osc_raw};

    // Registered read data, zero when no read is decoded
    r_d.hit   = (sfr_rd || sfr_wr) && (ctrl_sel || mult_sel);
    r_d.rdata = 8'h00;
    if (sfr_rd && ctrl_sel) begin
      r_d.rdata = ctrl_img;
    end else if (sfr_rd && mult_sel) begin
      r_d.rdata = ioc_pkg::MULT_IMAGE; // RL7 RL8 RL9 RL4
    end

    // Control writes; the multiplier register has no writable bits
    if (sfr_wr && ctrl_sel) begin
      r_d.on     = sfr_wdata[ioc_pkg::HF_ON_BIT]; // RL1
      r_d.hf_div = sfr_wdata[ioc_pkg::DIV_LSB +: 2]; // RL6
      if (sfr_wdata[ioc_pkg::HF_SUSP_BIT]) begin
        r_d.susp = 1'b1; // RL3
      end
    end

    // A wake clears only a suspend already set, so a new suspend write in the same cycle as a wake wins
    if (r_q.susp && wake) begin
      r_d.susp = 1'b0; // RL3 RL19
    end

    // Oscillator state; every restart settles before ready
    case (r_q.st)
      // Stopped: start settling once enabled and not suspended
      ioc_pkg::IOC_OFF: begin
        if (r_q.on && !r_q.susp) begin
          r_d.st = ioc_pkg::IOC_SETTLE;
          r_d.settle = 5'h00;
        end
      end

      // Settling: count fixed cycles before reporting ready
      ioc_pkg::IOC_SETTLE: begin
        r_d.settle = r_q.settle + 5'h01;
        if (!r_q.on) begin
          r_d.st = ioc_pkg::IOC_OFF;
        end else if (r_q.susp) begin
          r_d.st = ioc_pkg::IOC_SUSP;
        end else if (r_q.settle == 5'(ioc_pkg::HF_SETTLE_CYC - 1)) begin
          r_d.st = ioc_pkg::IOC_RUN; // RL20
        end
      end

      // Running at frequency
      ioc_pkg::IOC_RUN: begin
        if (!r_q.on) begin
          r_d.st = ioc_pkg::IOC_OFF; // RL20
        end else if (r_q.susp) begin
          r_d.st = ioc_pkg::IOC_SUSP; // RL20
        end
      end

      // Suspended: only a wake clears the request and restarts
      ioc_pkg::IOC_SUSP: begin
        if (!r_q.susp) begin
          r_d.st = ioc_pkg::IOC_OFF; // RL3
        end
      end

      default: r_d.st = ioc_pkg::IOC_OFF;
    endcase
    // Ready follows the next state so flag and state move together
    r_d.rdy = (r_d.st == ioc_pkg::IOC_RUN); // RL2 RL20

    // System clock enable: one pulse per divided period while running with clock select 000
    r_d.sys_en = 1'b0;
    r_d.hf_cnt = 5'h00;
    if (r_q.st == ioc_pkg::IOC_RUN && sys_clock_select == ioc_pkg::CLKSEL_HF_SCALED) begin
      r_d.hf_cnt = hf_step[4:0];
      r_d.sys_en = hf_step[5]; // RL18 RL5
    end

    // Low-frequency enable on every Nth rising edge; restart on a new divider
    r_d.lf_sel_last = lf_divider_select;
    r_d.lf_en       = 1'b0;
    if (r_q.lf_sel_last != lf_divider_select) begin
      r_d.lf_cnt = 3'h0;
    end else if (lf_rise) begin
      r_d.lf_cnt = lf_step[2:0];
      r_d.lf_en  = lf_step[5]; // RL12 RL16
    end

    // Trim passes through one register to the oscillator
    r_d.trim = lf_trim; // RL13

    // Capture: reload takes the count on the same edge as the pulse
    r_d.cap2 = t2_lf_capture_mode && lf_fall; // RL14
    r_d.cap3 = t3_lf_capture_mode && lf_rise; // RL14
    if (r_d.cap2) begin
      r_d.rl2 = t2_count; // RL15
    end
    if (r_d.cap3) begin
      r_d.rl3 = t3_count; // RL15
    end
  end

  // State register; reset loads the image above
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= RST_IMG; // RL1 RL2 RL3 RL6 RL16
    end else begin
      r_q <= r_d;
    end
  end

  // Every output comes straight from a state flop
  always_comb begin
    // Register read path
    sfr_rdata       = r_q.rdata;
    sfr_hit         = r_q.hit;
    // Oscillator status
    hf_osc_on       = r_q.on;
    hf_osc_suspend  = r_q.susp;
    hf_freq_ready   = r_q.rdy;
    // Clock enables and trim
    system_clock_en = r_q.sys_en;
    lf_clock_en     = r_q.lf_en;
    lf_trim_out     = r_q.trim;
    // Timer capture
    t2_capture      = r_q.cap2;
    t3_capture      = r_q.cap3;
    t2_reload       = r_q.rl2;
    t3_reload       = r_q.rl3;
  end

endmodule : ioc_top

// file: tb/ioc_host.sv
// Core-side SFR master model: one-cycle read or write strobe per access.
// Assumes read data answers one cycle after the strobe edge.
`timescale 1ns/1ps
module ioc_host (
  input wire logic       core_clk,
  output logic     [7:0] sfr_addr, sfr_page, sfr_wdata,
  output logic           sfr_wr, sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit
);
  initial {sfr_addr, sfr_page, sfr_wdata, sfr_wr, sfr_rd} = '0;
  task automatic acc(input logic w, input logic [7:0] a, p, d, output logic [7:0] q,
                     output logic h);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_page <= p;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= !w;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    // Released bus shows a changed value
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
    #1 q = sfr_rdata;
    h = sfr_hit;
  endtask : acc
endmodule : ioc_host

// file: tb/ioc_top_assertions.sv
// Checker on ioc_top ports: decode, flags, clock enable spacing, captures.
// Assumes one core_clk domain; bound into every ioc_top.
`timescale 1ns/1ps
module ioc_chk (
  input wire logic        core_clk, sys_rst, sfr_wr, sfr_rd, sfr_hit, hf_osc_on,
  input wire logic        hf_osc_suspend, hf_freq_ready, system_clock_en, t2_capture, t3_capture,
  input wire logic [7:0]  sfr_addr, sfr_page, sfr_wdata, sfr_rdata,
  input wire logic [15:0] t2_count, t3_count, t2_reload, t3_reload
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire b2 = sfr_addr == ioc_pkg::HF_CTRL_ADDR;
  wire b9 = sfr_addr == ioc_pkg::MULT_ADDR;
  a_ctrl_read: assert property (sfr_rd && b2 |=> sfr_hit && sfr_rdata[4:2] == 3'h0)
    else $error("control read bad");
  a_mult_image: assert property (sfr_rd && b9 && sfr_page == 8'h00 |=> sfr_rdata == 8'hE0)
    else $error("multiplier image bad");
  a_mult_page: assert property (sfr_rd && b9 && sfr_page != 8'h00 |=> !sfr_hit)
    else $error("multiplier decoded off page");
  a_rdata_idle: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not cleared");
  a_on_write: assert property (sfr_wr && b2 |=> hf_osc_on == $past(sfr_wdata[7]))
    else $error("enable bit not written");
  a_susp_set: assert property (sfr_wr && b2 && sfr_wdata[5] && !hf_osc_suspend |=> hf_osc_suspend)
    else $error("suspend not entered");
  a_rdy_off: assert property (hf_osc_suspend || !hf_osc_on |=> !hf_freq_ready)
    else $error("ready while stopped");
  a_rdy_settle: assert property ($fell(hf_freq_ready) |-> !hf_freq_ready [*8])
    else $error("ready back too soon");
  a_sys_gap: assert property (system_clock_en |=> !system_clock_en [*3])
    else $error("clock enables too close");
  a_t2_load: assert property (t2_capture |-> t2_reload == $past(t2_count))
    else $error("timer 2 reload bad");
  a_t3_load: assert property (t3_capture |-> t3_reload == $past(t3_count))
    else $error("timer 3 reload bad");
  c_t2: cover property (t2_capture);
  c_en: cover property (system_clock_en);
  c_rdy: cover property ($rose(hf_freq_ready));
endmodule : ioc_chk
bind ioc_top ioc_chk u_chk (.*);

// file: tb/tb_internal_oscillator_control.sv
// Testbench for ioc_top: register access, dividers, suspend, capture.
// Assumes ioc_host drives the SFR bus; t2_count doubles as cycle counter.
`timescale 1ns/1ps
module tb_internal_oscillator_control;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata;
  logic sfr_wr, sfr_rd, sfr_hit, hf_osc_on, hf_osc_suspend, hf_freq_ready;
  logic system_clock_en, lf_clock_en, t2_capture, t3_capture;
  logic [3:0] lf_trim_out;
  logic [15:0] t2_reload, t3_reload, t2_count = 16'h0000;
  wire [15:0] t3_count = ~t2_count;
  logic [2:0] sys_clock_select = 3'h0;
  logic [1:0] lf_divider_select = 2'h2;
  logic [3:0] lf_trim = 4'hA;
  logic usb_wake_event = 1'b0, bus_supply_detect = 1'b0, lf_osc_raw = 1'b0;
  logic t2_lf_capture_mode = 1'b0, t3_lf_capture_mode = 1'b0;
  int n_fail = 0, n_tests = 0, d, g, n2, n3, nl;
  ioc_top dut (.*);
  ioc_host host (.*);
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    t2_count <= t2_count + 16'h0001;
    if (t2_count[3:0] == 4'hF) lf_osc_raw <= ~lf_osc_raw;
    if (t2_count == 16'h4E20) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, p, e, input logic h);
    logic [7:0] q;
    logic hh;
    host.acc(1'b0, a, p, 8'h00, q, hh);
    chk({q, 7'h00, hh}, {e, 7'h00, h});
  endtask : rd
  task automatic wr(input logic [7:0] a, p, v);
    logic [7:0] q;
    logic hh;
    host.acc(1'b1, a, p, v, q, hh);
  endtask : wr
  task automatic gap(output int n);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        #1 n++;
      end while (system_clock_en !== 1'b1 && n < 99);
    end
  endtask : gap
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'hB2, 8'h00, 8'hC0, 1'b1);
    rd(8'hB9, 8'h00, 8'hE0, 1'b1);
    wr(8'hB9, 8'h00, 8'h1F);
    rd(8'hB9, 8'h00, 8'hE0, 1'b1);
    rd(8'hB9, 8'h01, 8'h00, 1'b0);
    rd(8'hB2, 8'h05, 8'hC0, 1'b1);
    $display("registers done");
    for (d = 0; d < 4; d++) begin
      wr(8'hB2, 8'h00, 8'h9C | d[7:0]);
      rd(8'hB2, 8'h00, 8'hC0 | d[7:0], 1'b1);
      gap(g);
      chk(16'(g), 16'h0020 >> d);
    end
    $display("dividers done");
    for (d = 0; d < 2; d++) begin
      wr(8'hB2, 8'h00, 8'hA3);
      rd(8'hB2, 8'h00, 8'hA3, 1'b1);
      @(posedge core_clk);
      if (d == 0) bus_supply_detect <= ~bus_supply_detect;
      else usb_wake_event <= 1'b1;
      repeat (4) @(posedge core_clk);
      usb_wake_event <= 1'b0;
      repeat (30) @(posedge core_clk);
      rd(8'hB2, 8'h00, 8'hC3, 1'b1);
    end
    wr(8'hB2, 8'h00, 8'h03);
    rd(8'hB2, 8'h00, 8'h03, 1'b1);
    wr(8'hB2, 8'h00, 8'h83);
    repeat (24) @(posedge core_clk);
    rd(8'hB2, 8'h00, 8'hC3, 1'b1);
    $display("suspend done");
    @(posedge core_clk);
    t2_lf_capture_mode <= 1'b1;
    t3_lf_capture_mode <= 1'b1;
    repeat (8) @(posedge core_clk);
    {n2, n3, nl} = '0;
    repeat (128) begin
      @(posedge core_clk);
      #1;
      n2 += t2_capture;
      n3 += t3_capture;
      nl += lf_clock_en;
    end
    chk(16'(n2), 16'h0004);
    chk(16'(n3), 16'h0004);
    chk(16'(nl), 16'h0002);
    chk({12'h000, lf_trim_out}, 16'h000A);
    $display("capture done");
    report_and_stop();
  end
endmodule : tb_internal_oscillator_control
